/* File: bbar_cfg.svh */
`ifndef BBAR_CFG_SVH
`define BBAR_CFG_SVH

// Bit-band regions: lowest 64 KB of SRAM and lowest 1 MB of the peripheral region
`define BBAR_SRAM_BAND_BASE 32'h20000000
`define BBAR_SRAM_BAND_LAST 32'h2000FFFF
`define BBAR_SRAM_ALIAS_BASE 32'h22000000
`define BBAR_SRAM_ALIAS_LAST 32'h221FFFFF
`define BBAR_PERI_BAND_BASE 32'h40000000
`define BBAR_PERI_BAND_LAST 32'h400FFFFF
`define BBAR_PERI_ALIAS_BASE 32'h42000000
`define BBAR_PERI_ALIAS_LAST 32'h43FFFFFF
// Alias address fields
`define BBAR_BIT_LSB 2
`define BBAR_BIT_MSB 4
`define BBAR_BYTE_LSB 5
`define BBAR_BYTE_MSB 24

`endif

/* File: bbar_pkg.sv */
package bbar_pkg;
    typedef enum logic [1:0] {
        BBAR_SIZE_BYTE = 2'h0,
        BBAR_SIZE_HALF = 2'h1,
        BBAR_SIZE_WORD = 2'h2
    } bbar_size_e;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic fetch;
        bbar_size_e size;
        logic [31:0] wdata;
    } bbar_req_s;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        bbar_size_e size;
        logic [31:0] wdata;
        logic [3:0] strb;
    } bbar_mreq_s;
endpackage

/* File: bbar_remap.sv */
`timescale 1ns/1ns
`include "bbar_cfg.svh"
module bbar_remap (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Processor side
    input wire logic req_valid_in,
    input wire bbar_pkg::bbar_req_s req_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [31:0] rsp_rdata_out,
    output logic rsp_error_out,
    // Memory side
    output logic mem_valid_out,
    output bbar_pkg::bbar_mreq_s mem_req_out,
    input wire logic mem_ready_in,
    input wire logic mem_rsp_valid_in,
    input wire logic [31:0] mem_rdata_in
);
    import bbar_pkg::*;

    typedef enum logic [5:0] {
        BBAR_IDLE = 6'h01,
        BBAR_ISSUE = 6'h02,
        BBAR_WAIT = 6'h04,
        BBAR_WRITE = 6'h08,
        BBAR_WWAIT = 6'h10,
        BBAR_DONE = 6'h20
    } bbar_state_e;

    bbar_state_e state_q, state_d;
    bbar_req_s req_q;
    logic alias_q;
    logic [31:0] rdata_q;
    logic err_q;

    typedef enum logic [4:0] {
        BBAR_RGN_OTHER = 5'h01,
        BBAR_RGN_SRAM_BAND = 5'h02,
        BBAR_RGN_SRAM_ALIAS = 5'h04,
        BBAR_RGN_PERI_BAND = 5'h08,
        BBAR_RGN_PERI_ALIAS = 5'h10
    } bbar_region_e;
    bbar_region_e region;
    wire [31:0] in_addr = req_in.addr;

    // Band hits pass like any other address; named to keep the map visible
    always_comb begin
        if (in_addr >= `BBAR_SRAM_ALIAS_BASE
            && in_addr <= `BBAR_SRAM_ALIAS_LAST) begin
            region = BBAR_RGN_SRAM_ALIAS;
        end else if (in_addr >= `BBAR_PERI_ALIAS_BASE
            && in_addr <= `BBAR_PERI_ALIAS_LAST) begin
            region = BBAR_RGN_PERI_ALIAS;
        end else if (in_addr >= `BBAR_SRAM_BAND_BASE
            && in_addr <= `BBAR_SRAM_BAND_LAST) begin
            region = BBAR_RGN_SRAM_BAND;
        end else if (in_addr >= `BBAR_PERI_BAND_BASE
            && in_addr <= `BBAR_PERI_BAND_LAST) begin
            region = BBAR_RGN_PERI_BAND;
        end else begin
            region = BBAR_RGN_OTHER;
        end
    end
    wire in_sram_alias = region == BBAR_RGN_SRAM_ALIAS;
    wire in_peri_alias = region == BBAR_RGN_PERI_ALIAS;
    // Fetches through SRAM alias go straight through untouched
    wire do_remap = (in_sram_alias || in_peri_alias) && !req_in.fetch;
    wire fetch_fault = in_peri_alias && req_in.fetch;
    wire accept = req_valid_in && state_q == BBAR_IDLE;

    // Target byte in the band (64 KB SRAM, 1 MB peripheral) under the matching alias window
    wire [19:0] byte_off = req_q.addr[`BBAR_BYTE_MSB:`BBAR_BYTE_LSB];
    wire [2:0] bit_num = req_q.addr[`BBAR_BIT_MSB:`BBAR_BIT_LSB];
    // Bit 30 splits the SRAM and peripheral alias windows
    wire [31:0] band_base = req_q.addr[30] ? `BBAR_PERI_BAND_BASE : `BBAR_SRAM_BAND_BASE;
    wire [31:0] band_byte = band_base | {12'h000, byte_off};
    // Aligned address for the chosen size; lanes follow the aligned address
    logic [31:0] band_addr;
    always_comb begin
        if (req_q.size == BBAR_SIZE_WORD) begin
            band_addr = {band_byte[31:2], 2'h0};
        end else if (req_q.size == BBAR_SIZE_HALF) begin
            band_addr = {band_byte[31:1], 1'h0};
        end else begin
            band_addr = band_byte;
        end
    end
    wire [4:0] bit_pos = {band_byte[1:0], bit_num};
    wire [31:0] bit_mask = 32'h00000001 << bit_pos;
    // Only bit 0 of the written value matters; the rest keep read data
    wire [31:0] rmw_data;
    for (genvar g = 0; g < 32; g++) begin : g_rmw
        assign rmw_data[g] = bit_mask[g] ? req_q.wdata[0] : rdata_q[g];
    end

    logic [3:0] size_strb;
    always_comb begin
        if (req_q.size == BBAR_SIZE_WORD) begin
            size_strb = 4'hF;
        end else if (req_q.size == BBAR_SIZE_HALF) begin
            size_strb = 4'h3;
        end else begin
            size_strb = 4'h1;
        end
    end
    wire [3:0] lane_strb = size_strb << band_addr[1:0];
    wire [3:0] pass_strb = size_strb << req_q.addr[1:0];

    assign req_ready_out = state_q == BBAR_IDLE;
    assign mem_valid_out = state_q == BBAR_ISSUE || state_q == BBAR_WRITE;
    assign rsp_valid_out = state_q == BBAR_DONE;
    assign rsp_error_out = err_q;

    // Direct band and all other addresses pass unchanged
    always_comb begin
        mem_req_out.addr = req_q.addr;
        mem_req_out.write = req_q.write;
        mem_req_out.size = req_q.size;
        mem_req_out.wdata = req_q.wdata;
        mem_req_out.strb = pass_strb;
        if (alias_q) begin
            mem_req_out.addr = band_addr;
            mem_req_out.write = state_q == BBAR_WRITE;
            mem_req_out.wdata = rmw_data;
            mem_req_out.strb = lane_strb;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            BBAR_IDLE: begin
                if (accept) begin
                    state_d = fetch_fault ? BBAR_DONE : BBAR_ISSUE;
                end
            end
            BBAR_ISSUE: begin
                if (mem_ready_in) begin
                    state_d = BBAR_WAIT;
                end
            end
            BBAR_WAIT: begin
                if (mem_rsp_valid_in) begin
                    state_d = (alias_q && req_q.write) ? BBAR_WRITE : BBAR_DONE;
                end
            end
            BBAR_WRITE: begin
                if (mem_ready_in) begin
                    state_d = BBAR_WWAIT;
                end
            end
            BBAR_WWAIT: begin
                if (mem_rsp_valid_in) begin
                    state_d = BBAR_DONE;
                end
            end
            BBAR_DONE: begin
                state_d = BBAR_IDLE;
            end
            default: begin
                state_d = BBAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= BBAR_IDLE;
            req_q <= '0;
            alias_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (accept) begin
                req_q <= req_in;
                alias_q <= do_remap;
                err_q <= fetch_fault;
            end
        end
    end

    // Read data of the first phase is kept for the modify step
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 32'h00000000;
        end else if (accept) begin
            rdata_q <= 32'h00000000;
        end else if (state_q == BBAR_WAIT && mem_rsp_valid_in) begin
            rdata_q <= mem_rdata_in;
        end else if (state_q == BBAR_DONE && alias_q) begin
            rdata_q <= rdata_q;
        end
    end

    // Alias answer is reduced to the single targeted bit
    logic [31:0] rsp_q;
    wire [31:0] rsp_d = alias_q ? {31'h00000000, mem_rdata_in[bit_pos]} : mem_rdata_in;
    // Refused fetches answer zero without touching memory
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rsp_q <= 32'h00000000;
        end else if (accept) begin
            rsp_q <= 32'h00000000;
        end else if (state_q == BBAR_WAIT && mem_rsp_valid_in) begin
            rsp_q <= rsp_d;
        end
    end
    assign rsp_rdata_out = rsp_q;
endmodule

/* File: bbar_remap_props.sv */
`timescale 1ns/1ns
module bbar_remap_props (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire bbar_pkg::bbar_req_s req_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic [31:0] rsp_rdata_out,
    input wire logic rsp_error_out,
    input wire logic mem_valid_out,
    input wire bbar_pkg::bbar_mreq_s mem_req_out
);
    import bbar_pkg::*;
    logic [31:0] ad_q, wd_q;
    logic wr_q, al_q, pf_q;
    bbar_size_e sz_q;
    wire hit = req_valid_in && req_ready_out;
    wire peri = req_in.addr[31:25] == 7'h21;
    wire alias_hit = (req_in.addr[31:21] == 11'h110) || peri;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            al_q <= 1'b0;
            pf_q <= 1'b0;
        end else if (hit) begin
            ad_q <= req_in.addr;
            wd_q <= req_in.wdata;
            wr_q <= req_in.write;
            sz_q <= req_in.size;
            al_q <= alias_hit && !req_in.fetch;
            pf_q <= peri && req_in.fetch;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    property p_band; mem_valid_out && !al_q |-> mem_req_out.addr == ad_q; endproperty
    a_band: assert property (p_band) else $error("direct address altered");
    property p_map; mem_valid_out && al_q |-> mem_req_out.addr[31:2] == {ad_q[31:28], 8'h00, ad_q[24:7]}; endproperty
    a_map: assert property (p_map) else $error("alias address mapped wrong");
    property p_size; mem_valid_out |-> mem_req_out.size == sz_q; endproperty
    a_size: assert property (p_size) else $error("access size changed");
    property p_wbit; mem_valid_out && mem_req_out.write && al_q |-> mem_req_out.wdata[ad_q[6:2]] == wd_q[0]; endproperty
    a_wbit: assert property (p_wbit) else $error("alias write bit wrong");
    property p_rd; rsp_valid_out && al_q && !wr_q |-> rsp_rdata_out[31:1] == 31'h0; endproperty
    a_rd: assert property (p_rd) else $error("alias read upper bits set");
    property p_perr; rsp_valid_out && pf_q |-> rsp_error_out; endproperty
    a_perr: assert property (p_perr) else $error("peripheral alias fetch allowed");
    property p_nomem; pf_q |-> !mem_valid_out; endproperty
    a_nomem: assert property (p_nomem) else $error("refused fetch reached memory");
    property p_done; hit |-> ##[1:16] rsp_valid_out; endproperty
    a_done: assert property (p_done) else $error("no response");
endmodule
bind bbar_remap bbar_remap_props i_props (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
    .rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
    .rsp_error_out(rsp_error_out), .mem_valid_out(mem_valid_out), .mem_req_out(mem_req_out));

/* File: bbar_mem_model.sv */
`timescale 1ns/1ns
module bbar_mem_model (
    input wire logic clk_in,
    input wire logic valid_in,
    input wire bbar_pkg::bbar_mreq_s req_in,
    output logic ready_out,
    output logic rsp_valid_out,
    output logic [31:0] rdata_out
);
    import bbar_pkg::*;
    logic [31:0] mem [16];
    assign ready_out = valid_in;
    initial begin
        rsp_valid_out = 1'b0;
        rdata_out = '0;
        foreach (mem[i]) mem[i] = '0;
    end
    always @(posedge clk_in) begin
        // Every accepted access is answered, writes too
        rsp_valid_out <= valid_in;
        // Idle bus toggles so stale data never looks valid
        rdata_out <= valid_in ? mem[req_in.addr[5:2]] : ~rdata_out;
        for (int i = 0; i < 4; i++)
            if (valid_in && req_in.write && req_in.strb[i])
                mem[req_in.addr[5:2]][8*i+:8] <= req_in.wdata[8*i+:8];
    end
endmodule

/* File: bbar_remap_bench.sv */
`timescale 1ns/1ns
module bbar_remap_bench;
    import bbar_pkg::*;
    logic mclk_in = 0, rst_n_in = 0, req_valid_in = 0, req_ready_out, rsp_valid_out;
    logic rsp_error_out, mem_valid_out, mem_ready_in, mem_rsp_valid_in, er;
    logic [31:0] rsp_rdata_out, mem_rdata_in, q;
    bbar_req_s req_in = '0;
    bbar_mreq_s mem_req_out;
    int mismatches = 0, checked = 0, cyc = 0;
    initial forever #4 mclk_in = ~mclk_in;
    bbar_remap i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
        .req_in(req_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
        .rsp_rdata_out(rsp_rdata_out), .rsp_error_out(rsp_error_out),
        .mem_valid_out(mem_valid_out), .mem_req_out(mem_req_out), .mem_ready_in(mem_ready_in),
        .mem_rsp_valid_in(mem_rsp_valid_in), .mem_rdata_in(mem_rdata_in));
    bbar_mem_model i_mem (.clk_in(mclk_in), .valid_in(mem_valid_out), .req_in(mem_req_out),
        .ready_out(mem_ready_in), .rsp_valid_out(mem_rsp_valid_in), .rdata_out(mem_rdata_in));
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic [31:0] a, input logic w, f, input logic [31:0] d,
        input bbar_size_e s = BBAR_SIZE_WORD);
        int n;
        n = 0;
        @(negedge mclk_in);
        req_in = '{a, w, f, s, d};
        req_valid_in = 1'b1;
        do @(posedge mclk_in); while (req_ready_out !== 1'b1 && ++n < 20);
        @(negedge mclk_in);
        req_valid_in = 1'b0;
        while (rsp_valid_out !== 1'b1 && ++n < 40) @(negedge mclk_in);
        chk("response", 1, n < 40);
        q = rsp_rdata_out;
        er = rsp_error_out;
    endtask
    task t_direct;
        acc(32'h20000004, 1, 0, 32'hA5A50F0F);
        acc(32'h20000004, 0, 0, 0);
        chk("direct", 32'hA5A50F0F, q);
        $display("direct test done");
    endtask
    task t_alias;
        acc(32'h20000004, 1, 0, 0);
        for (int b = 0; b < 8; b++) begin
            // Upper ones must not leak into the bit
            acc(32'h220000A0 + 4 * b, 1, 0, {31'h7FFFFFFF, b[0]});
            acc(32'h220000A0 + 4 * b, 0, 0, 0);
            chk("alias read", {31'h0, b[0]}, q);
        end
        acc(32'h20000004, 0, 0, 0);
        chk("band byte", 32'h0000AA00, q);
        $display("alias test done");
    endtask
    task t_peri;
        acc(32'h40000008, 1, 0, 32'hFFFFFFFF);
        acc(32'h4200011C, 1, 0, 32'h0000000E);
        acc(32'h40000008, 0, 0, 0);
        chk("peri band", 32'hFFFFFF7F, q);
        acc(32'h4200011C, 1, 0, 32'h00000001, BBAR_SIZE_BYTE);
        acc(32'h4200011C, 0, 0, 0, BBAR_SIZE_HALF);
        chk("sized alias", 1, q);
        acc(32'h40000008, 0, 0, 0);
        chk("byte lane", 32'hFFFFFFFF, q);
        acc(32'h4200011C, 0, 1, 0);
        chk("peri fetch", 1, er);
        acc(32'h220000A0, 0, 1, 0);
        chk("sram fetch", 0, er);
        $display("peripheral test done");
    endtask
    task give_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge mclk_in) begin
        if (++cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge mclk_in);
        rst_n_in = 1'b1;
        t_direct();
        t_alias();
        t_peri();
        give_verdict();
    end
endmodule
